// file: core/vhbi_consts.svh
`ifndef VHBI_CONSTS_SVH
`define VHBI_CONSTS_SVH
`define VHBI_IO_ATTR        10'h3C0
`define VHBI_IO_SEQ         10'h3C4
`define VHBI_IO_GFX         10'h3CE
`define VHBI_IO_CRT_MONO    10'h3B4
`define VHBI_IO_CRT_COLOR   10'h3D4
`define VHBI_IO_DAC_LO      10'h3C6
`define VHBI_IO_DAC_HI      10'h3C9
`define VHBI_IO_EXT_INDEX   10'h3D6
`define VHBI_IO_EXT_DATA    10'h3D7
`define VHBI_EXT_IDX_CFG    8'h00
`define VHBI_EXT_IDX_ENA    8'h01
`define VHBI_EXT_IDX_LATCH0 8'h10
`define VHBI_EXT_IDX_ATTRFF 8'h14
`define VHBI_EXT_KEY        8'hA5
`define VHBI_CFG_BIT_MEM16  0
`define VHBI_CFG_BIT_IO16   1
`define VHBI_ENA_BIT        7
`define VHBI_ROM_BASE       20'hC0000
`define VHBI_ROM_MASK       20'hF8000
`define VHBI_MEM_BASE       20'hA0000
`define VHBI_MEM_MASK       20'hE0000
`define VHBI_CFG_RESET      8'h00
`endif

// file: core/vhbi_pkg.sv
package vhbi_pkg;
    typedef enum logic [3:0] {
        VHBI_IDLE  = 4'b0001,
        VHBI_MREQ  = 4'b0010,
        VHBI_MWAIT = 4'b0100,
        VHBI_MDONE = 4'b1000
    } vhbi_state_type;

    typedef struct packed {
        vhbi_state_type st;
        logic [2:0]     bus_mc_sync;
        logic [2:0]     mem_go_sync;
        logic [2:0]     dot_sync;
        logic [1:0]     strap_cnt;
        logic           mc_mode;
        logic [7:0]     cfg;
        logic           key_ok;
        logic           ena_ok;
        logic [7:0]     ext_idx;
        logic [7:0]     attr_idx;
        logic           attr_ff;
        logic [7:0]     seq_idx;
        logic [7:0]     gfx_idx;
        logic [7:0]     crt_idx;
        logic [15:0]    rd_data;
        logic           mem_strobe;
        logic           io_prev;
    } vhbi_regs_type;
endpackage : vhbi_pkg

// file: core/vhbi_host_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "vhbi_consts.svh"
// Operation
// (RULE1) a strap sampled after reset picks pc-bus or channel-bus control generation
// (RULE2) 16-bit transfers enabled separately for memory and i/o cycles
// (RULE3) after reset both memory and i/o accesses are 8-bit
// (RULE4) 16-bit i/o allowed only at the four index/data pairs
// (RULE5) every other i/o address is always an 8-bit port
// (RULE6) a0 and bhe decide whether a cycle runs 8 or 16 bits
// (RULE7) i/o cycles finish with no wait states
// (RULE8) memory cycles hold wait until display memory access completes
// (RULE9) pc-bus mode decodes the bios rom range and drives its select
// (RULE10) channel-bus mode never selects an external rom
// (RULE11) the whole 256 kbyte memory reachable in 4, 2 and 1 plane modes; the code reaches it only in 4-plane mode, the others reach 128 kbyte
// (RULE12) display memory strobes are timed from the dot clock
// (RULE13) system supplies a 25-40 mhz memory clock for 16-bit sequencing
// (RULE14) all extended functions disabled after reset
// (RULE15) extended writes ignored until two enable sets are both set
// (RULE16) extended space reads return processor latches and attribute flip-flop
// (RULE17) standard registers gain no bits and unused bits stay meaningless
// (RULE18) i/o 3c6h to 3c9h address the external palette dac
// (RULE19) palette accesses drive dac read or write strobe per direction
// (RULE20) fast-link accesses complete faster than other peripherals
// (RULE21) 16-bit index/data write loads index low and data high
module vhbi_host_if #(
    parameter int MEM_ADDR_W = 18
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  bus_select_strap_i,
    input  wire logic                  fast_link_i,
    input  wire logic                  io_rd_i,
    input  wire logic                  io_wr_i,
    input  wire logic                  mem_rd_i,
    input  wire logic                  mem_wr_i,
    input  wire logic [19:0]           addr_i,
    input  wire logic                  bhe_n_i,
    input  wire logic [15:0]           wdata_i,
    input  wire logic                  dot_clk_i,
    input  wire logic                  mem_done_i,
    input  wire logic [1:0]            plane_mode_i,
    input  wire logic [31:0]           proc_latch_i,
    output logic      [15:0]           rdata_o,
    output logic                       io16_o,
    output logic                       mem16_o,
    output logic                       ready_o,
    output logic                       bios_rom_select_o,
    output logic                       dac_rd_o,
    output logic                       dac_wr_o,
    output logic                       mem_req_o,
    output logic      [MEM_ADDR_W-1:0] mem_addr_o,
    output logic      [1:0]            mem_plane_o,
    output logic                       mem_strobe_o,
    output logic                       idx_wr_o,
    output logic                       data_wr_o,
    output logic      [9:0]            port_o,
    output logic      [7:0]            index_o,
    output logic      [7:0]            data_o,
    output logic                       ext_active_o
);
    vhbi_pkg::vhbi_regs_type r_r;
    vhbi_pkg::vhbi_regs_type r_nxt;

    function automatic logic is_pair(input logic [9:0] a);
        is_pair = (a == `VHBI_IO_ATTR) || (a == `VHBI_IO_SEQ) || (a == `VHBI_IO_GFX) ||
                  (a == `VHBI_IO_CRT_MONO) || (a == `VHBI_IO_CRT_COLOR);
    endfunction : is_pair

    function automatic logic in_range(input logic [19:0] a, input logic [19:0] b, input logic [19:0] m);
        in_range = ((a & m) == b);
    endfunction : in_range

    logic [9:0] port;
    logic       io_acc;
    logic       io_edge;
    logic       pair_hit;
    logic       io16_cyc;
    logic       mem_hit;
    logic       dac_hit;
    logic       ext_data_hit;
    logic       ext_unlocked;
    logic       mem_go;
    logic       mem_ack;
    logic       dot_rise;

    assign port     = addr_i[9:0];
    assign io_acc   = io_rd_i | io_wr_i;
    assign io_edge  = io_acc & ~r_r.io_prev;
    assign pair_hit = is_pair(port);
    assign dac_hit  = (port >= `VHBI_IO_DAC_LO) && (port <= `VHBI_IO_DAC_HI);                    // [RULE18]
    assign ext_data_hit = (port == `VHBI_IO_EXT_DATA);
    assign ext_unlocked = r_r.key_ok & r_r.ena_ok;                                                  // [RULE15]
    // wide only when enabled, at a pair, even address, high byte requested
    assign io16_cyc = r_r.cfg[`VHBI_CFG_BIT_IO16] & pair_hit & ~addr_i[0] & ~bhe_n_i; // [RULE4] [RULE5] [RULE6]
    assign mem_hit  = in_range(addr_i, `VHBI_MEM_BASE, `VHBI_MEM_MASK);
    assign mem_go   = r_r.mem_go_sync[1];
    assign mem_ack  = r_r.mem_go_sync[2];
    assign dot_rise = r_r.dot_sync[1] & ~r_r.dot_sync[2];

    always_comb
    begin
        r_nxt = r_r;
        r_nxt.io_prev     = io_acc;
        r_nxt.bus_mc_sync = {r_r.bus_mc_sync[1:0], bus_select_strap_i};
        r_nxt.mem_go_sync = {r_r.mem_go_sync[1:0], mem_done_i};
        r_nxt.dot_sync    = {r_r.dot_sync[1:0], dot_clk_i};
        if (r_r.strap_cnt != 2'h3)
        begin
            // strap followed until the sync chain has filled, then frozen; earlier values are reset zeros
            r_nxt.strap_cnt = r_r.strap_cnt + 2'h1;
            r_nxt.mc_mode   = r_r.bus_mc_sync[1];                                                  // [RULE1]
        end
        if (io_edge && io_wr_i)
        begin
            if (io16_cyc)
            begin
                // [RULE21]
                case (port)
                    `VHBI_IO_SEQ:       r_nxt.seq_idx = wdata_i[7:0];
                    `VHBI_IO_GFX:       r_nxt.gfx_idx = wdata_i[7:0];
                    `VHBI_IO_ATTR:      r_nxt.attr_idx = wdata_i[7:0];
                    default:            r_nxt.crt_idx = wdata_i[7:0];
                endcase
            end
            else
            begin
                case (port)
                    `VHBI_IO_SEQ:       r_nxt.seq_idx = wdata_i[7:0];
                    `VHBI_IO_GFX:       r_nxt.gfx_idx = wdata_i[7:0];
                    `VHBI_IO_CRT_MONO:  r_nxt.crt_idx = wdata_i[7:0];
                    `VHBI_IO_CRT_COLOR: r_nxt.crt_idx = wdata_i[7:0];
                    `VHBI_IO_ATTR:
                    begin
                        if (!r_r.attr_ff)
                        begin
                            r_nxt.attr_idx = wdata_i[7:0];
                        end
                        r_nxt.attr_ff = ~r_r.attr_ff;
                    end
                    `VHBI_IO_EXT_INDEX: r_nxt.ext_idx = wdata_i[7:0];
                    `VHBI_IO_EXT_DATA:
                    begin
                        // two separate enable sets: a key, then an enable bit
                        if (r_r.ext_idx == `VHBI_EXT_IDX_ENA)
                        begin
                            r_nxt.key_ok = (wdata_i[7:0] == `VHBI_EXT_KEY);
                        end
                        else if (r_r.ext_idx == `VHBI_EXT_IDX_CFG && r_r.key_ok)
                        begin
                            r_nxt.ena_ok = wdata_i[`VHBI_ENA_BIT];
                            if (r_r.ena_ok)
                            begin
                                r_nxt.cfg = wdata_i[7:0];                                           // [RULE2] [RULE15]
                            end
                        end
                        else
                        begin
                            r_nxt.key_ok = r_r.key_ok;
                        end
                    end
                    default:
                    begin
                        r_nxt.io_prev = io_acc;
                    end
                endcase
            end
        end
        if (io_edge && io_rd_i)
        begin
            r_nxt.rd_data = 16'h0000;
            case (port)
                `VHBI_IO_SEQ:       r_nxt.rd_data = {8'h00, r_r.seq_idx};
                `VHBI_IO_GFX:       r_nxt.rd_data = {8'h00, r_r.gfx_idx};
                `VHBI_IO_CRT_MONO:  r_nxt.rd_data = {8'h00, r_r.crt_idx};
                `VHBI_IO_CRT_COLOR: r_nxt.rd_data = {8'h00, r_r.crt_idx};
                `VHBI_IO_ATTR:      r_nxt.rd_data = {8'h00, r_r.attr_idx};                          // [RULE17]
                `VHBI_IO_EXT_INDEX: r_nxt.rd_data = {8'h00, r_r.ext_idx};
                `VHBI_IO_EXT_DATA:
                begin
                    if (ext_unlocked)
                    begin
                        case (r_r.ext_idx)
                            `VHBI_EXT_IDX_CFG:        r_nxt.rd_data = {8'h00, r_r.cfg};
                            `VHBI_EXT_IDX_LATCH0:     r_nxt.rd_data = {8'h00, proc_latch_i[7:0]};  // [RULE16]
                            8'h11:                    r_nxt.rd_data = {8'h00, proc_latch_i[15:8]};
                            8'h12:                    r_nxt.rd_data = {8'h00, proc_latch_i[23:16]};
                            8'h13:                    r_nxt.rd_data = {8'h00, proc_latch_i[31:24]};
                            `VHBI_EXT_IDX_ATTRFF:     r_nxt.rd_data = {15'h0000, r_r.attr_ff};     // [RULE16]
                            default:                  r_nxt.rd_data = 16'h0000;
                        endcase
                    end
                end
                default:            r_nxt.rd_data = 16'h0000;
            endcase
        end
        r_nxt.mem_strobe = 1'b0;
        case (r_r.st)
            vhbi_pkg::VHBI_IDLE:
            begin
                if ((mem_rd_i || mem_wr_i) && mem_hit)
                begin
                    r_nxt.st = vhbi_pkg::VHBI_MREQ;
                end
            end
            vhbi_pkg::VHBI_MREQ:
            begin
                if (dot_rise)
                begin
                    r_nxt.mem_strobe = 1'b1;                                                        // [RULE12]
                    r_nxt.st = vhbi_pkg::VHBI_MWAIT;
                end
            end
            vhbi_pkg::VHBI_MWAIT:
            begin
                if (mem_go && !mem_ack)
                begin
                    r_nxt.st = vhbi_pkg::VHBI_MDONE;                                                // [RULE8]
                end
            end
            vhbi_pkg::VHBI_MDONE:
            begin
                if (!mem_rd_i && !mem_wr_i)
                begin
                    r_nxt.st = vhbi_pkg::VHBI_IDLE;
                end
            end
            default:
            begin
                r_nxt.st = vhbi_pkg::VHBI_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r_r <= '0;
            r_r.st <= vhbi_pkg::VHBI_IDLE;
            r_r.cfg <= `VHBI_CFG_RESET;                                                             // [RULE3] [RULE14]
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // plane mode folds the byte address; only the default 4-plane mode spans the full 256 kbyte array, modes 01 and 10 reach 128 kbyte
    always_comb
    begin
        case (plane_mode_i)                                                                         // [RULE11]
            2'b01:   mem_addr_o = {addr_i[16:1], 2'b00} | MEM_ADDR_W'(addr_i[0]);
            2'b10:   mem_addr_o = MEM_ADDR_W'(addr_i[16:0]) << 1;
            default: mem_addr_o = {addr_i[15:0], 2'b00};
        endcase
        case (plane_mode_i)
            2'b01:   mem_plane_o = {1'b0, addr_i[0]};
            2'b10:   mem_plane_o = addr_i[1:0];
            default: mem_plane_o = 2'b00;
        endcase
    end

    assign rdata_o      = r_r.rd_data;
    assign io16_o       = io_acc & io16_cyc;
    assign mem16_o      = r_r.cfg[`VHBI_CFG_BIT_MEM16] & ~addr_i[0] & ~bhe_n_i & mem_hit;          // [RULE2] [RULE6]
    // i/o never waits; display memory waits until completion, fast link saves the idle turn
    assign ready_o      = ~(mem_rd_i | mem_wr_i) | ~mem_hit |                                       // [RULE7]
                          (r_r.st == vhbi_pkg::VHBI_MDONE) |
                          (fast_link_i & (r_r.st == vhbi_pkg::VHBI_MWAIT) & mem_go);                // [RULE20]
    assign bios_rom_select_o = ~r_r.mc_mode & (r_r.strap_cnt == 2'h3) & mem_rd_i &                  // [RULE9] [RULE10]
                               in_range(addr_i, `VHBI_ROM_BASE, `VHBI_ROM_MASK);
    assign dac_rd_o     = io_rd_i & dac_hit;                                                        // [RULE19]
    assign dac_wr_o     = io_wr_i & dac_hit;                                                        // [RULE19]
    assign mem_req_o    = (r_r.st == vhbi_pkg::VHBI_MREQ) | (r_r.st == vhbi_pkg::VHBI_MWAIT);
    assign mem_strobe_o = r_r.mem_strobe;
    assign idx_wr_o     = io_edge & io_wr_i & pair_hit;
    assign data_wr_o    = io_edge & io_wr_i & (io16_cyc | (port == `VHBI_IO_ATTR & r_r.attr_ff) |
                          (is_pair({port[9:1], 1'b0}) & port[0] & (port != `VHBI_IO_ATTR + 10'h001)) |
                          (ext_data_hit & ext_unlocked));
    assign port_o       = io16_cyc ? (port + 10'h001) : port;
    assign index_o      = wdata_i[7:0];
    assign data_o       = io16_cyc ? wdata_i[15:8] : wdata_i[7:0];
    assign ext_active_o = ext_unlocked;
endmodule : vhbi_host_if
`default_nettype wire

// file: tb/vhbi_host_if_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "vhbi_consts.svh"
module vhbi_host_if_checker (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic        bus_select_strap_i,
    input wire logic        io_rd_i,
    input wire logic        io_wr_i,
    input wire logic        mem_rd_i,
    input wire logic [19:0] addr_i,
    input wire logic        bhe_n_i,
    input wire logic        io16_o,
    input wire logic        mem16_o,
    input wire logic        ready_o,
    input wire logic        bios_rom_select_o,
    input wire logic        dac_rd_o,
    input wire logic        dac_wr_o,
    input wire logic        idx_wr_o,
    input wire logic        ext_active_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [1:0] cyc_r;
    logic       seen_r;
    logic       dac_a;
    logic       pair_a;
    logic       win_a;
    assign dac_a  = addr_i[9:0] >= `VHBI_IO_DAC_LO && addr_i[9:0] <= `VHBI_IO_DAC_HI;
    assign pair_a = addr_i[9:0] inside {`VHBI_IO_ATTR, `VHBI_IO_SEQ, `VHBI_IO_GFX, `VHBI_IO_CRT_MONO,
                                        `VHBI_IO_CRT_COLOR};
    assign win_a  = (addr_i & `VHBI_MEM_MASK) == `VHBI_MEM_BASE;
    // cycle count since reset, so the first edges can be judged on their own
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cyc_r  <= 2'h0;
            seen_r <= 1'b0;
        end
        else
        begin
            cyc_r  <= (cyc_r == 2'h3) ? cyc_r : cyc_r + 2'h1;
            seen_r <= seen_r | ext_active_o;
        end
    end
    AST_IO_NO_WAIT: assert property ((io_rd_i || io_wr_i) |-> ready_o) else $error("io wait");
    AST_DAC_WR: assert property (io_wr_i && dac_a |-> dac_wr_o && !dac_rd_o) else $error("dac wr");
    AST_DAC_RD: assert property (io_rd_i && dac_a |-> dac_rd_o && !dac_wr_o) else $error("dac rd");
    AST_DAC_ONLY: assert property ((dac_rd_o || dac_wr_o) |-> dac_a && (io_rd_i || io_wr_i))
        else $error("stray dac strobe");
    AST_IO16_WHERE: assert property
        ((io_rd_i || io_wr_i) && io16_o |-> pair_a && !addr_i[0] && !bhe_n_i) else $error("bad io16");
    AST_WIDTH_RESET: assert property (!seen_r && !ext_active_o |-> !io16_o && !mem16_o)
        else $error("wide before unlock");
    AST_EXT_OFF: assert property (cyc_r < 2'h2 |-> !ext_active_o) else $error("ext on after reset");
    AST_MEM_WAIT: assert property ($rose(mem_rd_i) && win_a |=> !ready_o [*3]) else $error("mem no wait");
    AST_MEM_DONE: assert property ($rose(mem_rd_i) && win_a |-> ##[4:40] ready_o) else $error("mem hang");
    AST_ROM_PC: assert property (bios_rom_select_o |-> !bus_select_strap_i &&
        (addr_i & `VHBI_ROM_MASK) == `VHBI_ROM_BASE) else $error("rom select");
    AST_IDX_PULSE: assert property
        ($rose(io_wr_i) && addr_i[9:0] == `VHBI_IO_SEQ |-> idx_wr_o ##1 !idx_wr_o) else $error("index pulse");
    cover property (io16_o);
    cover property ($rose(mem_rd_i) && win_a ##[4:40] ready_o);
    cover property (bios_rom_select_o);
endmodule : vhbi_host_if_checker
bind vhbi_host_if vhbi_host_if_checker i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .bus_select_strap_i(bus_select_strap_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .mem_rd_i(mem_rd_i),
    .addr_i(addr_i), .bhe_n_i(bhe_n_i), .io16_o(io16_o), .mem16_o(mem16_o), .ready_o(ready_o),
    .bios_rom_select_o(bios_rom_select_o), .dac_rd_o(dac_rd_o), .dac_wr_o(dac_wr_o),
    .idx_wr_o(idx_wr_o), .ext_active_o(ext_active_o));
`default_nettype wire

// file: tb/vhbi_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module vhbi_mem_model #(
    parameter int DONE_DLY = 3
) (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic strobe_i,
    input  wire logic busy_i,
    output logic      dot_clk_o,
    output logic      done_o
);
    logic [1:0] div_r;
    logic [3:0] cnt_r;
    // dot clock runs free, as a display raster needs it to
    assign dot_clk_o = div_r[1];
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_r  <= 2'h0;
            cnt_r  <= 4'h0;
            done_o <= 1'b0;
        end
        else
        begin
            div_r <= div_r + 2'h1;
            if (!busy_i)
            begin
                cnt_r  <= 4'h0;
                done_o <= 1'b0;
            end
            else if (strobe_i)
                cnt_r <= 4'h1;
            else if (cnt_r != 4'h0 && cnt_r < 4'(DONE_DLY))
                cnt_r <= cnt_r + 4'h1; // memory clock sequencing stood in by a fixed count
            else if (cnt_r == 4'(DONE_DLY))
                done_o <= 1'b1;
        end
    end
endmodule : vhbi_mem_model
`default_nettype wire

// file: tb/vga_host_bus_interface_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "vhbi_consts.svh"
module vga_host_bus_interface_bench;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        strap = 1'b0;
    logic        fast = 1'b0;
    logic        io_rd = 1'b0;
    logic        io_wr = 1'b0;
    logic        mem_rd = 1'b0;
    logic        mem_wr = 1'b0;
    logic [9:0]  port;
    logic [9:0]  psnap;
    logic        bhe_n = 1'b1;
    logic [19:0] addr = 20'h00000;
    logic [15:0] wdata = 16'h0000;
    logic [1:0]  plane = 2'h0;
    logic [31:0] latch = 32'h00000000;
    logic [15:0] rdata;
    logic        io16, mem16, ready, rom, dac_rd, dac_wr, mem_req, strobe, idx_wr, data_wr, ext_act, dot, done;
    logic [7:0]  index, data;
    logic [20:0] snap;
    logic [1:0]  msnap;
    logic        pend = 1'b0;
    logic        prev_rd = 1'b0;
    logic [7:0]  exp_q[$];
    logic [9:0]  pairs[5] = '{`VHBI_IO_ATTR, `VHBI_IO_SEQ, `VHBI_IO_GFX, `VHBI_IO_CRT_MONO, `VHBI_IO_CRT_COLOR};
    int          seed = 32'hd8e0;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    vhbi_host_if i_vhbi_host_if (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_select_strap_i(strap),
        .fast_link_i(fast), .io_rd_i(io_rd), .io_wr_i(io_wr), .mem_rd_i(mem_rd), .mem_wr_i(mem_wr),
        .addr_i(addr), .bhe_n_i(bhe_n), .wdata_i(wdata), .dot_clk_i(dot), .mem_done_i(done),
        .plane_mode_i(plane), .proc_latch_i(latch), .rdata_o(rdata), .io16_o(io16), .mem16_o(mem16),
        .ready_o(ready), .bios_rom_select_o(rom), .dac_rd_o(dac_rd), .dac_wr_o(dac_wr), .mem_req_o(mem_req),
        .mem_addr_o(), .mem_plane_o(), .mem_strobe_o(strobe), .idx_wr_o(idx_wr), .data_wr_o(data_wr),
        .port_o(port), .index_o(index), .data_o(data), .ext_active_o(ext_act));
    vhbi_mem_model i_vhbi_mem_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .strobe_i(strobe),
        .busy_i(mem_rd | mem_wr), .dot_clk_o(dot), .done_o(done));
    task automatic stop_test();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rst();
        rst_n_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
    endtask : rst
    // one io cycle, then one idle cycle so the next is seen as a fresh start
    task automatic io(input logic rd, input logic [9:0] a, input logic bn, input logic [15:0] d);
        io_rd <= rd;
        io_wr <= !rd;
        addr <= {10'h000, a};
        bhe_n <= bn;
        wdata <= d;
        @(negedge ref_clk_i);
        snap = {io16, dac_rd, dac_wr, idx_wr, data_wr, index, data};
        psnap = port;
        @(posedge ref_clk_i);
        io_rd <= 1'b0;
        io_wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask : io
    task automatic xw(input logic [7:0] i, input logic [7:0] v);
        io(1'b0, `VHBI_IO_EXT_INDEX, 1'b1, {8'h00, i});
        io(1'b0, `VHBI_IO_EXT_DATA, 1'b1, {8'h00, v});
    endtask : xw
    task automatic mem(input logic [19:0] a, input logic wr);
        int n;
        n = 0;
        mem_rd <= !wr;
        mem_wr <= wr;
        addr <= a;
        bhe_n <= 1'b0;
        @(negedge ref_clk_i);
        msnap = {mem16, rom};
        while ((a & `VHBI_MEM_MASK) == `VHBI_MEM_BASE && !(ready && n > 0) && n < 60)
        begin
            @(negedge ref_clk_i);
            n++;
        end
        chk("mem_ready", 16'h1, {15'h0, ready});
        @(posedge ref_clk_i);
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask : mem
    always @(posedge ref_clk_i)
    begin
        if (pend && exp_q.size() > 0)
            chk("ext_read", {8'h00, exp_q.pop_front()}, {8'h00, rdata[7:0]});
        pend <= io_rd && !prev_rd && addr[9:0] == `VHBI_IO_EXT_DATA;
        prev_rd <= io_rd;
        cycles++;
        if (cycles > 20000)
        begin
            miscompares++;
            stop_test();
        end
    end
    initial
    begin
        logic [15:0] d;
        latch <= $random(seed);
        rst();
        io(1'b0, `VHBI_IO_SEQ, 1'b0, 16'h0102);
        chk("io16_reset", 16'h0, {15'h0, snap[20]});
        mem(20'hA0000, 1'b0);
        chk("mem16_reset", 16'h0, {15'h0, msnap[1]});
        xw(`VHBI_EXT_IDX_CFG, 8'h83);
        io(1'b0, `VHBI_IO_SEQ, 1'b0, 16'h0102);
        chk("io16_locked", 16'h0, {15'h0, snap[20]});
        xw(`VHBI_EXT_IDX_ENA, `VHBI_EXT_KEY);
        xw(`VHBI_EXT_IDX_CFG, 8'h80);
        xw(`VHBI_EXT_IDX_CFG, 8'h83);
        chk("ext_active", 16'h1, {15'h0, ext_act});
        foreach (pairs[i])
        begin
            d = 16'($random(seed));
            io(1'b0, pairs[i], 1'b0, d);
            chk("io16_pair", 16'h3, {14'h0, snap[20], snap[17] & snap[16]});
            chk("index_data", d, {snap[7:0], snap[15:8]});
            chk("data_port", {6'h00, pairs[i] + 10'h001}, {6'h00, psnap});
        end
        io(1'b1, `VHBI_IO_CRT_COLOR, 1'b1, 16'h0000);
        chk("crt_index", {8'h00, d[7:0]}, rdata);
        io(1'b0, `VHBI_IO_SEQ, 1'b1, 16'h0102);
        chk("io16_bhe", 16'h0, {15'h0, snap[20]});
        for (int a = 10'h3C5; a <= 10'h3CA; a++)
        begin
            io(1'b1, 10'(a), 1'b0, 16'h0000);
            chk("dac_rd", {15'h0, a >= 10'h3C6 && a <= 10'h3C9}, {15'h0, snap[19]});
            chk("io16_dac", 16'h0, {15'h0, snap[20]});
        end
        io(1'b0, 10'h3C8, 1'b0, 16'h1234);
        chk("dac_wr", 16'h1, {14'h0, snap[20], snap[18]});
        for (int k = 0; k < 4; k++)
        begin
            io(1'b0, `VHBI_IO_EXT_INDEX, 1'b1, 16'(`VHBI_EXT_IDX_LATCH0 + k));
            exp_q.push_back(latch[k*8 +: 8]);
            io(1'b1, `VHBI_IO_EXT_DATA, 1'b1, 16'h0000);
        end
        for (int p = 0; p < 3; p++)
        begin
            plane <= 2'(p);
            fast <= p[0];
            mem({3'b101, 16'($random(seed)), 1'b0}, p[0]);
            chk("mem16", 16'h1, {15'h0, msnap[1]});
        end
        mem(20'hC4000, 1'b0);
        chk("rom_in", 16'h1, {15'h0, msnap[0]});
        mem(20'hC8000, 1'b0);
        chk("rom_out", 16'h0, {15'h0, msnap[0]});
        strap <= 1'b1;
        rst();
        mem(20'hC4000, 1'b0);
        chk("rom_channel", 16'h0, {15'h0, msnap[0]});
        stop_test();
    end
endmodule : vga_host_bus_interface_bench
`default_nettype wire
